// ===== ppf_pkg.sv
/*
 * Shared constants and carrier types for the channel output sense and trip
 * status block of the eight-channel PWM timer module.
 * Assumes a 32-bit APB register bus with byte addresses and the timer's single
 * system clock for all producers of the carried signals.
 */
package ppf_pkg;

    localparam int PPF_CHANNELS = 8;
    localparam int PPF_TRIP_INPUTS = 4;
    localparam int PPF_ADDR_W = 12;

    // Register indices, one aligned 32-bit word per index.
    localparam logic [PPF_ADDR_W-1:0] PPF_IDX_SENSE = 12'h024;
    localparam logic [PPF_ADDR_W-1:0] PPF_IDX_STATUS = 12'h025;
    localparam logic [PPF_ADDR_W-1:0] PPF_ADDR_SENSE = 12'h090;
    localparam logic [PPF_ADDR_W-1:0] PPF_ADDR_STATUS = 12'h094;

    // Trip status field positions.
    localparam int PPF_BIT_COMBINED = 7;
    localparam int PPF_BIT_LOCK_ON = 6;
    localparam int PPF_BIT_LEVEL = 5;
    localparam int PPF_BIT_RSVD = 4;

    // Reset values.
    localparam logic [7:0] PPF_SENSE_RST = 8'h00;
    localparam logic [3:0] PPF_TRIP_RST = 4'h0;
    localparam logic [7:0] PPF_OUT_RST = 8'h00;
    localparam logic [31:0] PPF_RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PPF_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ppf_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ppf_apb_rsp_t;

    // Trip signals from the detection and filter logic, same clock.
    typedef struct packed {
        logic ctrl_en;
        logic [PPF_TRIP_INPUTS-1:0] input_en;
        logic [PPF_TRIP_INPUTS-1:0] detect;
        logic [PPF_TRIP_INPUTS-1:0] level;
    } ppf_trip_in_t;

    // Handshake toward the mode register that owns the lock-off bit.
    typedef struct packed {
        logic set_req;
        logic release_ok;
    } ppf_lock_ctl_t;

endpackage

// ===== ppf_polarity_fault.sv
/*
 * Channel output sense register, trip status register and the safe-value
 * output stage of the eight-channel PWM timer module, as an APB slave.
 * Assumes the mode register lives elsewhere: it supplies the lock-off level,
 * a pulse when software writes 1 to lock-off, and honours the lock handshake.
 * The trip detection and filter logic run on clk_sys and feed ppf_trip_in_t.
 */
`timescale 1ns/1ps

// Function
// - On trip, outputs drive their sense value
// - Sense 0 active high, 1 active low
// - Sense writes only while lock-off is 1
// - Sense register index 24h, bit n channel n
// - Combined flag is OR of input flags
// - Combined clears by read, then write 0
// - New trip between read and write restarts
// - Clearing input flags clears combined flag
// - Lock-on reads inverse; writing 1 sets
// - Lock-on clears after read 1, lock-off write
// - Lock blocks protected writes, else allowed
// - Bit 5 is OR of enabled levels
// - Bit 4 reserved, reads 0
// - Input 3 flag sets on enabled trip
// - Input flag clears by read, write 0
// - Clearing combined flag clears all input flags
// - Status register index 25h, eight bits
// - Inputs 2 to 0 behave like input 3
// - New trip restarts input clearing sequence
module ppf_polarity_fault
    import ppf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire ppf_apb_req_t apb_req,
    output ppf_apb_rsp_t apb_rsp,
    input wire ppf_trip_in_t trip_in,
    input wire logic write_lock_off,
    input wire logic write_lock_off_wr,
    output ppf_lock_ctl_t lock_ctl,
    input wire logic [PPF_CHANNELS-1:0] pwm_demand,
    output logic [PPF_CHANNELS-1:0] channel_out
);

    // Decoding shared by the read path and the write path.
    function automatic logic [1:0] decode_reg(input logic [PPF_ADDR_W-1:0] addr);
        logic [1:0] hit;
        hit = 2'h0;
        if (addr == PPF_ADDR_SENSE) begin
            hit[0] = 1'b1;
        end
        if (addr == PPF_ADDR_STATUS) begin
            hit[1] = 1'b1;
        end
        return hit;
    endfunction

    logic [PPF_CHANNELS-1:0] channel_output_sense;
    logic [PPF_TRIP_INPUTS-1:0] input_trip_flag;
    logic [PPF_TRIP_INPUTS-1:0] input_clear_armed;
    logic combined_clear_armed;
    logic lock_release_armed;
    logic lock_set_pulse;
    logic [31:0] read_data;

    logic combined_trip_flag;
    logic write_lock_on;
    logic trip_inputs_level;
    logic [PPF_TRIP_INPUTS-1:0] enabled_detect;
    logic any_enabled_detect;
    logic any_enabled_level;
    logic [7:0] trip_status;

    logic setup_phase;
    logic access_done;
    logic [1:0] setup_hit;
    logic [1:0] access_hit;
    logic sense_write;
    logic status_write;
    logic status_read;
    logic combined_clear;
    logic [PPF_TRIP_INPUTS-1:0] input_clear;

    assign enabled_detect = trip_in.detect & trip_in.input_en & {PPF_TRIP_INPUTS{trip_in.ctrl_en}};
    assign any_enabled_detect = |enabled_detect;
    assign any_enabled_level = |(trip_in.level & trip_in.input_en);

    // Combined flag is derived, so clearing every input flag clears it too.
    assign combined_trip_flag = |input_trip_flag;

    assign write_lock_on = ~write_lock_off;

    assign trip_inputs_level = trip_in.ctrl_en & any_enabled_level;

    always_comb begin
        trip_status = 8'h00;
        trip_status[PPF_BIT_COMBINED] = combined_trip_flag;
        trip_status[PPF_BIT_LOCK_ON] = write_lock_on;
        trip_status[PPF_BIT_LEVEL] = trip_inputs_level;
        trip_status[PPF_BIT_RSVD] = 1'b0;
        trip_status[PPF_TRIP_INPUTS-1:0] = input_trip_flag;
    end

    // The slave never inserts wait states: each access completes at the
    // first rising edge of its access phase.
    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign access_done = apb_req.psel & apb_req.penable;
    assign setup_hit = decode_reg(apb_req.paddr);
    assign access_hit = decode_reg(apb_req.paddr);

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access_done & ~(|access_hit);
    assign apb_rsp.prdata = read_data;

    assign sense_write = access_done & apb_req.pwrite & access_hit[0] & apb_req.pstrb[0];
    assign status_write = access_done & apb_req.pwrite & access_hit[1] & apb_req.pstrb[0];
    assign status_read = access_done & ~apb_req.pwrite & access_hit[1];

    // Read data is captured in the setup cycle so it is a flop output by the
    // access phase; the clear sequences arm on what software actually saw.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            read_data <= PPF_RDATA_RST;
        end else if (setup_phase & ~apb_req.pwrite) begin
            if (setup_hit[0]) begin
                read_data <= {24'h000000, channel_output_sense};
            end else if (setup_hit[1]) begin
                read_data <= {24'h000000, trip_status};
            end else begin
                read_data <= PPF_RDATA_RST;
            end
        end
    end

    // Sense bits are write protected; writes under lock are dropped silently.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            channel_output_sense <= PPF_SENSE_RST;
        end else if (sense_write & write_lock_off) begin
            channel_output_sense <= apb_req.pwdata[PPF_CHANNELS-1:0];
        end
    end

    // Combined clear sequence: armed by a status read that showed the flag,
    // restarted by any new enabled trip, completed by writing 0 to bit 7
    // while no enabled input still shows a trip.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            combined_clear_armed <= 1'b0;
        end else if (any_enabled_detect) begin
            combined_clear_armed <= 1'b0;
        end else if (status_read & read_data[PPF_BIT_COMBINED]) begin
            combined_clear_armed <= 1'b1;
        end else if (combined_clear) begin
            combined_clear_armed <= 1'b0;
        end
    end

    assign combined_clear = status_write & combined_clear_armed & ~any_enabled_detect &
                            ~apb_req.pwdata[PPF_BIT_COMBINED] & ~any_enabled_level;

    genvar gi;
    generate
        for (gi = 0; gi < PPF_TRIP_INPUTS; gi = gi + 1) begin : g_trip
            // Per-input clear sequence, restarted by a new trip on this input.
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    input_clear_armed[gi] <= 1'b0;
                end else if (enabled_detect[gi]) begin
                    input_clear_armed[gi] <= 1'b0;
                end else if (status_read & read_data[gi]) begin
                    input_clear_armed[gi] <= 1'b1;
                end else if (input_clear[gi]) begin
                    input_clear_armed[gi] <= 1'b0;
                end
            end

            assign input_clear[gi] = status_write & input_clear_armed[gi] & ~enabled_detect[gi] &
                                     ~apb_req.pwdata[gi] & ~trip_in.level[gi];

            // A trip in the same cycle as a clear keeps the flag set.
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    input_trip_flag[gi] <= 1'b0;
                end else if (enabled_detect[gi]) begin
                    input_trip_flag[gi] <= 1'b1;
                end else if (input_clear[gi] | combined_clear) begin
                    input_trip_flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Writing 1 to lock-on asks the mode register to drop lock-off.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_set_pulse <= 1'b0;
        end else begin
            lock_set_pulse <= status_write & apb_req.pwdata[PPF_BIT_LOCK_ON];
        end
    end

    // Release is granted only after lock-on was read as 1; the mode register
    // lets a 1 into lock-off only while release_ok is high.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_release_armed <= 1'b0;
        end else if (lock_set_pulse | write_lock_off | write_lock_off_wr) begin
            lock_release_armed <= 1'b0;
        end else if (status_read & read_data[PPF_BIT_LOCK_ON]) begin
            lock_release_armed <= 1'b1;
        end
    end

    assign lock_ctl.set_req = lock_set_pulse;
    // A software write of 1 to lock-off uses up the release, so a second
    // attempt needs a fresh read of lock-on as 1.
    assign lock_ctl.release_ok = lock_release_armed;

    // Safe value on a trip is the sense bit, which is each channel's
    // inactive level; otherwise the demand is inverted for active-low sense.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            channel_out <= PPF_OUT_RST;
        end else if (trip_in.ctrl_en & combined_trip_flag) begin
            channel_out <= channel_output_sense;
        end else begin
            channel_out <= pwm_demand ^ channel_output_sense;
        end
    end

endmodule

// ===== ppf_props.sv
/* Port checker for ppf_polarity_fault.
   Assumes one clk_sys domain and bind onto every instance. */
`timescale 1ns/1ps
module ppf_props
    import ppf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire ppf_apb_req_t apb_req,
    input wire ppf_apb_rsp_t apb_rsp,
    input wire ppf_trip_in_t trip_in,
    input wire logic write_lock_off,
    input wire ppf_lock_ctl_t lock_ctl,
    input wire logic [PPF_CHANNELS-1:0] channel_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic bad;
    assign bad = apb_req.psel && apb_req.penable && apb_req.paddr != PPF_ADDR_SENSE && apb_req.paddr != PPF_ADDR_STATUS;
    sequence rd_st;
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == PPF_ADDR_STATUS;
    endsequence
    sequence wr_lock;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == PPF_ADDR_STATUS
            && apb_req.pstrb[0] && apb_req.pwdata[6];
    endsequence
    sequence trip;
        trip_in.ctrl_en && |(trip_in.detect & trip_in.input_en);
    endsequence
    chk_ready_high: assert property (apb_rsp.pready) else $error("pready low");
    chk_err_map: assert property (apb_rsp.pslverr == bad) else $error("pslverr wrong");
    chk_rdata_top: assert property (apb_rsp.prdata[31:8] == 24'h0) else $error("prdata top set");
    chk_lock_read: assert property (rd_st |=> apb_rsp.prdata[6] == !$past(write_lock_off))
        else $error("lock bit wrong");
    chk_rsvd_zero: assert property (rd_st |=> !apb_rsp.prdata[4]) else $error("bit 4 set");
    chk_level_or: assert property (rd_st |=> apb_rsp.prdata[5] ==
        $past(trip_in.ctrl_en && |(trip_in.level & trip_in.input_en))) else $error("level bit wrong");
    chk_combined_or: assert property (rd_st |=> apb_rsp.prdata[7] == |apb_rsp.prdata[3:0])
        else $error("combined wrong");
    chk_lock_pulse: assert property (wr_lock |=> lock_ctl.set_req ##1 !lock_ctl.set_req)
        else $error("set_req wrong");
    chk_safe_out: assert property (trip ##1 (trip_in.ctrl_en && !apb_req.psel)[*4] |-> $stable(channel_out))
        else $error("output not safe");
endmodule
bind ppf_polarity_fault ppf_props u_ppf_props (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .trip_in(trip_in), .write_lock_off(write_lock_off), .lock_ctl(lock_ctl), .channel_out(channel_out));

// ===== ppf_lock_model.sv
/* Mode register lock-off bit on the far side of the lock handshake.
   Assumes sw_set is a one-cycle software write of 1 on clk_sys. */
`timescale 1ns/1ps
module ppf_lock_model
    import ppf_pkg::*;
#(
    parameter logic LOCK_OFF_RST = 1'b0
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sw_set,
    input wire ppf_lock_ctl_t lock_ctl,
    output logic write_lock_off,
    output logic write_lock_off_wr
);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_lock_off <= LOCK_OFF_RST;
        end else if (lock_ctl.set_req) begin
            write_lock_off <= 1'b0;
        end else if (sw_set && lock_ctl.release_ok) begin
            write_lock_off <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) write_lock_off_wr <= 1'b0;
        else write_lock_off_wr <= sw_set;
    end
endmodule

// ===== ppf_polarity_fault_tb_top.sv
/* Self-checking bench for ppf_polarity_fault with a lock-off model.
   Assumes the 10 MHz clk_sys and a zero-wait APB slave. */
`timescale 1ns/1ps
module ppf_polarity_fault_tb_top
    import ppf_pkg::*;
;
    logic clk_sys = 0, rst = 1, sw_set = 0, wlo, wlo_wr;
    ppf_apb_req_t req = '0;
    ppf_apb_rsp_t rsp;
    ppf_trip_in_t trip = '0;
    ppf_lock_ctl_t lck;
    logic [7:0] pwm = 8'h00, cout;
    logic [31:0] rd;
    int num_errors = 0, n_tests = 0, seed = 32'hd3beb7aa, exp_sense = 0, exp_flag = 0, exp_lock = 0;
    ppf_polarity_fault u_ppf_polarity_fault (.clk_sys(clk_sys), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .trip_in(trip), .write_lock_off(wlo), .write_lock_off_wr(wlo_wr), .lock_ctl(lck),
        .pwm_demand(pwm), .channel_out(cout));
    ppf_lock_model u_ppf_lock_model (.clk_sys(clk_sys), .rst(rst), .sw_set(sw_set), .lock_ctl(lck),
        .write_lock_off(wlo), .write_lock_off_wr(wlo_wr));
    initial forever #50 clk_sys = ~clk_sys;
    task close_out;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        @(posedge clk_sys);
        while (rsp.pready !== 1'b1) begin
            k++;
            if (k > 20) begin
                num_errors++;
                close_out();
            end
            @(posedge clk_sys);
        end
        rd = rsp.prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    function automatic logic [31:0] exp_st();
        return {24'h0, exp_flag != 0, exp_lock == 0, trip.ctrl_en && |(trip.level & trip.input_en), 1'b0,
            exp_flag[3:0]};
    endfunction
    task rd_st;
        apb(1'b0, PPF_ADDR_STATUS, 32'h0);
        chk(rd, exp_st());
    endtask
    task pulse(input logic [3:0] m);
        @(posedge clk_sys);
        trip.detect <= m;
        @(posedge clk_sys);
        trip.detect <= 4'h0;
        exp_flag |= m;
    endtask
    task done(input int n);
        $display("test %0d done", n);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end
    initial begin
        int i;
        logic [31:0] d;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, PPF_ADDR_SENSE, 32'h0);
        chk(rd, 32'h0);
        rd_st();
        done(1);
        apb(1'b1, PPF_ADDR_SENSE, 32'hFF);
        apb(1'b0, PPF_ADDR_SENSE, 32'h0);
        chk(rd, exp_sense);
        apb(1'b0, 12'h098, 32'h0);
        chk(rd, 32'h0);
        done(2);
        rd_st();
        @(posedge clk_sys);
        sw_set <= 1'b1;
        @(posedge clk_sys);
        sw_set <= 1'b0;
        exp_lock = 1;
        @(posedge clk_sys);
        chk(wlo, 1);
        rd_st();
        done(3);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            apb(1'b1, PPF_ADDR_SENSE, d);
            exp_sense = d & 8'hFF;
            apb(1'b0, PPF_ADDR_SENSE, 32'h0);
            chk(rd, exp_sense);
            pwm <= $random(seed);
            repeat (2) @(posedge clk_sys);
            chk(cout, pwm ^ exp_sense);
        end
        done(4);
        trip.ctrl_en <= 1'b1;
        trip.input_en <= 4'hF;
        for (i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            rd_st();
        end
        pulse(4'h8);
        repeat (5) @(posedge clk_sys);
        chk(cout, exp_sense);
        done(5);
        trip.level <= 4'h1;
        rd_st();
        apb(1'b1, PPF_ADDR_STATUS, 32'hBE);
        rd_st();
        trip.level <= 4'h0;
        rd_st();
        pulse(4'h2);
        apb(1'b1, PPF_ADDR_STATUS, 32'hBD);
        rd_st();
        pulse(4'h1);
        apb(1'b1, PPF_ADDR_STATUS, 32'h0F);
        rd_st();
        apb(1'b1, PPF_ADDR_STATUS, 32'h0F);
        exp_flag = 0;
        rd_st();
        done(6);
        pulse(4'h4);
        rd_st();
        apb(1'b1, PPF_ADDR_STATUS, 32'h80);
        exp_flag = 0;
        rd_st();
        repeat (2) @(posedge clk_sys);
        chk(cout, pwm ^ exp_sense);
        done(7);
        apb(1'b1, PPF_ADDR_STATUS, 32'h40);
        exp_lock = 0;
        repeat (3) @(posedge clk_sys);
        chk(wlo, 0);
        apb(1'b1, PPF_ADDR_SENSE, 32'h0);
        apb(1'b0, PPF_ADDR_SENSE, 32'h0);
        chk(rd, exp_sense);
        done(8);
        close_out();
    end
endmodule
